// ---- src/twg_pkg.sv ----
// Package for the tamper and waveform guard of the backup data bank.
// Assumes a single 25 MHz clock domain and an APB register port.
package twg_pkg;

  // Clock figures
  localparam int TWG_CLK_PERIOD_NS = 40;
  // Half period of the check square wave, in ns
  localparam int TWG_WAVE_HALF_NS = 1000;
  // Half period rounds down to whole cycles, never below one
  localparam int TWG_WAVE_HALF_CYC =
    (TWG_WAVE_HALF_NS / TWG_CLK_PERIOD_NS) < 1 ? 1 : (TWG_WAVE_HALF_NS / TWG_CLK_PERIOD_NS);

  // Bus widths
  localparam int TWG_ADDR_W = 8;
  localparam int TWG_DATA_W = 32;

  // Backup bank geometry
  localparam int TWG_BKP_WORDS = 42;
  localparam int TWG_BKP_W = 16;

  // Register byte offsets
  localparam logic [7:0] TWG_OFS_CTRL_A = 8'h00; // intrusion_a_control
  localparam logic [7:0] TWG_OFS_CTRL_B = 8'h04; // intrusion_b_control
  localparam logic [7:0] TWG_OFS_IER = 8'h08;    // intrusion_irq_event_reg
  localparam logic [7:0] TWG_OFS_STAT = 8'h0C;   // Sticky event status
  localparam logic [7:0] TWG_OFS_MASK = 8'h10;   // Interrupt mask
  localparam logic [7:0] TWG_OFS_BKP = 8'h40;    // First backup data word

  // Tamper control fields
  localparam int TWG_CTL_EN = 0;    // tamper enable
  localparam int TWG_CTL_HIGH = 1;  // 1: active high, 0: active low
  localparam int TWG_CTL_WAVE = 2;  // wave check select

  // Interrupt and event control fields
  localparam int TWG_IER_TIRQ = 0;  // tamper interrupt enable
  localparam int TWG_IER_TEVT = 1;  // tamper event enable
  localparam int TWG_IER_WIRQ = 2;  // wave interrupt enable
  localparam int TWG_IER_WEVT = 3;  // wave event enable
  localparam int TWG_IER_FLAG_A = 8;
  localparam int TWG_IER_FLAG_B = 9;

  // Status and mask fields
  localparam int TWG_ST_TA = 0;     // tamper_a_event_flag
  localparam int TWG_ST_TB = 1;     // tamper_b_event_flag
  localparam int TWG_ST_WA = 2;     // wave check a fault
  localparam int TWG_ST_WB = 3;     // wave check b fault
  localparam int TWG_ST_W = 4;

  // Reset values
  localparam logic [2:0] TWG_CTL_RST = 3'h0;
  localparam logic [3:0] TWG_IER_RST = 4'h0;
  localparam logic [3:0] TWG_ST_RST = 4'h0;

  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [TWG_ADDR_W-1:0] paddr;
    logic [TWG_DATA_W-1:0] pwdata;
  } twg_apb_req_type;

  // APB answer to the master
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [TWG_DATA_W-1:0] prdata;
  } twg_apb_rsp_type;

  // Pad levels seen by the block
  typedef struct packed {
    logic first_intrusion_pad;
    logic second_intrusion_pad;
    logic osc_out_pad;
  } twg_pad_in_type;

  // Pad drive from the block
  typedef struct packed {
    logic first_intrusion_pad_o;
    logic first_intrusion_pad_oe;
    logic osc_in_pad_o;
    logic osc_in_pad_oe;
  } twg_pad_out_type;

endpackage

// ---- src/twg_wave_check.sv ----
// Square wave generator and loop-back checker for one waveform path.
// Assumes the looped-back pad is synchronous to the clock.
`timescale 1ns/10ps
`default_nettype none
module twg_wave_check #(
  parameter int HALF_CYC = twg_pkg::TWG_WAVE_HALF_CYC
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic enable,
  input wire logic wave_in,
  output logic wave_o,
  output logic wave_oe,
  output logic fault
);
  import twg_pkg::*;

  localparam int CW = $clog2(HALF_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

  // Whole state of the checker
  typedef struct packed {
    logic [CW-1:0] cnt; // Position in the half period
    logic out;          // Level driven on the pad
    logic oe;           // Pad driven while enabled
    logic fault;        // One-cycle mismatch pulse
  } twg_wc_state_type;

  twg_wc_state_type st_r;
  twg_wc_state_type st_nxt;

  // Next state: toggle at end of each half, checking the loop first
  always_comb begin
    st_nxt = st_r;
    st_nxt.fault = 1'b0;
    st_nxt.oe = enable;
    if (!enable) begin
      // Idle: wave stopped, count parked
      st_nxt.cnt = '0;
      st_nxt.out = 1'b0;
    end else if (st_r.cnt == LAST) begin
      // Level had a whole half period to come back
      st_nxt.fault = st_r.oe && (wave_in != st_r.out);
      st_nxt.cnt = '0;
      st_nxt.out = ~st_r.out;
    end else begin
      st_nxt.cnt = st_r.cnt + CW'(1);
    end
  end

  // State register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wave_o = st_r.out;
  assign wave_oe = st_r.oe;
  assign fault = st_r.fault;

endmodule
`default_nettype wire

// ---- src/twg_guard.sv ----
// Tamper and waveform guard with a bank of backup data words, on APB.
// Assumes one clock, pads synchronous to it, pad wiring resolved outside.
// Pads are sampled directly; any debouncing must live outside.
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module twg_guard #(
  parameter int BKP_WORDS = twg_pkg::TWG_BKP_WORDS,
  parameter int WAVE_HALF_CYC = twg_pkg::TWG_WAVE_HALF_CYC
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire twg_pkg::twg_apb_req_type apb_req,
  output twg_pkg::twg_apb_rsp_type apb_rsp,
  input wire twg_pkg::twg_pad_in_type pad_in,
  output twg_pkg::twg_pad_out_type pad_out,
  output logic irq,
  output logic tamper_event
);
  import twg_pkg::*;

  // Whole control state of the guard
  typedef struct packed {
    twg_apb_rsp_type rsp;          // Registered bus answer
    logic [2:0] ctrl_a;            // intrusion_a_control
    logic [2:0] ctrl_b;            // intrusion_b_control
    logic [3:0] ier;               // intrusion_irq_event_reg enables
    logic [TWG_ST_W-1:0] status;   // Sticky event bits
    logic [TWG_ST_W-1:0] mask;     // Interrupt mask
    logic prev_a;                  // Last active-level view of pad a
    logic prev_b;                  // Last active-level view of pad b
    logic irq;                     // Interrupt output
    logic evt;                     // Event output pulse
  } twg_state_type;

  twg_state_type st_r;
  twg_state_type st_nxt;

  // Bank left out of reset on purpose: system reset and wake-up
  // must not touch user data, only a wipe clears it.
  // Limitation: after power-up the words read as unknown until
  // software writes them or a wipe clears them.
  // Backup bank, deliberately outside the reset tree
  logic [TWG_BKP_W-1:0] bkp_mem [BKP_WORDS];

  // Wave path signals
  logic wave_a_o;
  logic wave_a_oe;
  logic wave_a_fault;
  logic wave_b_o;
  logic wave_b_oe;
  logic wave_b_fault;

  // Control register fields
  logic tamper_a_enable;
  logic tamper_b_enable;
  logic wave_check_a_select;
  logic wave_check_b_select;

  // Active-level pad views and detected edges
  logic act_a;
  logic act_b;
  logic hit_a;
  logic hit_b;

  // Event sources and the bank wipe
  logic any_tamper;
  logic any_wave;
  logic wipe;

  // Bus decode
  logic acc;
  logic wr;
  logic bkp_hit;
  logic [TWG_ADDR_W-1:0] bkp_ofs;
  logic [TWG_ADDR_W-3:0] bkp_idx;

  // Per-bit status set and interrupt class
  logic [TWG_ST_W-1:0] set_bits;
  logic [TWG_ST_W-1:0] class_en;

  // Rising edge into the active level, gated by enable
  // Shared by both inputs so they detect in the same way
  function automatic logic twg_edge(input logic prev, input logic cur, input logic en);
    twg_edge = en && cur && !prev;
  endfunction

  // Active-level view of a pad: high when the pad is at its active level
  // Low-active inputs are inverted here, and only here
  function automatic logic twg_active(input logic pad, input logic high);
    twg_active = high ? pad : ~pad;
  endfunction

  // Field views of the control registers
  assign tamper_a_enable = st_r.ctrl_a[TWG_CTL_EN];
  assign tamper_b_enable = st_r.ctrl_b[TWG_CTL_EN];
  assign wave_check_a_select = st_r.ctrl_a[TWG_CTL_WAVE];
  assign wave_check_b_select = st_r.ctrl_b[TWG_CTL_WAVE];

  // Pad a is an output while wave a runs, so its tamper sense is muted
  assign act_a = twg_active(pad_in.first_intrusion_pad, st_r.ctrl_a[TWG_CTL_HIGH]);
  // Pad b carries the loop-back of wave a; its tamper sense is muted then
  assign act_b = twg_active(pad_in.second_intrusion_pad, st_r.ctrl_b[TWG_CTL_HIGH]);

  // Edges are taken on the active-level view, so a switch already
  // active when software arms the input does not count; only a
  // fresh move into the active level does.
  // Trade-off: a pulse that starts and ends between two clock edges is missed entirely.
  // Detected tamper edges
  assign hit_a = twg_edge(st_r.prev_a, act_a, tamper_a_enable && !wave_check_a_select);
  assign hit_b = twg_edge(st_r.prev_b, act_b, tamper_b_enable && !wave_check_a_select);

  assign any_tamper = hit_a || hit_b;
  assign any_wave = wave_a_fault || wave_b_fault;
  // Any event from any of the four sources wipes the bank
  assign wipe = any_tamper || any_wave;

  // A wave fault also raises the second tamper flag, so software
  // that only watches the two flags still sees it.
  // Bits set this cycle; wave faults land on the second flag too
  always_comb begin
    set_bits = '0;
    set_bits[TWG_ST_TA] = hit_a;
    set_bits[TWG_ST_TB] = hit_b || any_wave;
    set_bits[TWG_ST_WA] = wave_a_fault;
    set_bits[TWG_ST_WB] = wave_b_fault;
  end

  // The second flag serves tamper b and wave faults alike, so
  // either interrupt class lets it through.
  // Interrupt class enables lined up with status bits
  always_comb begin
    class_en = '0;
    class_en[TWG_ST_TA] = st_r.ier[TWG_IER_TIRQ];
    class_en[TWG_ST_TB] = st_r.ier[TWG_IER_TIRQ] || st_r.ier[TWG_IER_WIRQ];
    class_en[TWG_ST_WA] = st_r.ier[TWG_IER_WIRQ];
    class_en[TWG_ST_WB] = st_r.ier[TWG_IER_WIRQ];
  end

  // Register map, byte addresses, one word each:
  //   control a and control b: enable, active level, wave select
  //   irq and event control: tamper irq, tamper event, wave irq,
  //   wave event, plus the two tamper flags on their own bits
  //   status: tamper a, tamper b, wave a fault, wave b fault
  //   mask: same layout as status, gates the interrupt
  //   backup words from the bank base, low half word only
  // Any other address answers with an error and ignores writes.
  // The flags read the same through the control word and through
  // the status word; a one written to either place clears them.
  //
  // Bus timing: pready is a flop set by the setup cycle, so every
  // transfer takes exactly one access cycle and no wait states.
  // Read data is prepared in the setup cycle and dropped again
  // after the access cycle, so the answer lines idle at zero.
  //

  // Bus decode: writes and reads take effect in the access cycle with pready
  // acc only fires in the access cycle that pready marks
  assign acc = apb_req.psel && apb_req.penable && st_r.rsp.pready;
  assign wr = acc && apb_req.pwrite;
  assign bkp_ofs = apb_req.paddr - TWG_OFS_BKP;
  assign bkp_idx = bkp_ofs[TWG_ADDR_W-1:2];
  // Range check keeps the bank index inside the array
  assign bkp_hit = (apb_req.paddr >= TWG_OFS_BKP) && (bkp_ofs[1:0] == 2'h0)
                   && (int'(bkp_idx) < BKP_WORDS);

  // One process builds the whole next state; the level views
  // track the pads every cycle, armed or not.
  // Next control state
  always_comb begin
    st_nxt = st_r;
    st_nxt.prev_a = act_a;
    st_nxt.prev_b = act_b;

    // Bus answer: one wait-free access phase after each setup cycle
    st_nxt.rsp.pready = apb_req.psel && !apb_req.penable;
    if (apb_req.psel && !apb_req.penable) begin
      // Setup cycle: prepare read data and error for the access phase
      st_nxt.rsp.pslverr = 1'b0;
      st_nxt.rsp.prdata = '0;
      case (apb_req.paddr)
        TWG_OFS_CTRL_A: begin
          st_nxt.rsp.prdata[2:0] = st_r.ctrl_a;
        end
        TWG_OFS_CTRL_B: begin
          st_nxt.rsp.prdata[2:0] = st_r.ctrl_b;
        end
        TWG_OFS_IER: begin
          // Flags mirrored next to their enables
          st_nxt.rsp.prdata[3:0] = st_r.ier;
          st_nxt.rsp.prdata[TWG_IER_FLAG_A] = st_r.status[TWG_ST_TA];
          st_nxt.rsp.prdata[TWG_IER_FLAG_B] = st_r.status[TWG_ST_TB];
        end
        TWG_OFS_STAT: begin
          st_nxt.rsp.prdata[TWG_ST_W-1:0] = st_r.status;
        end
        TWG_OFS_MASK: begin
          st_nxt.rsp.prdata[TWG_ST_W-1:0] = st_r.mask;
        end
        default: begin
          if (bkp_hit) begin
            // Read of a backup word; a wipe in flight may still show old data
            st_nxt.rsp.prdata[TWG_BKP_W-1:0] = bkp_mem[bkp_idx];
          end else begin
            // Unmapped: error answer, data zero
            st_nxt.rsp.pslverr = 1'b1;
          end
        end
      endcase
    end else begin
      // Access or idle: the answer stood its one cycle, drop it
      st_nxt.rsp.pslverr = 1'b0;
      st_nxt.rsp.prdata = '0;
    end

    // Writes land at the access edge, when pready is already high;
    // unmapped writes fall to the default branch and change nothing.
    // Register writes; enable is expected to be set last by software
    if (wr) begin
      case (apb_req.paddr)
        TWG_OFS_CTRL_A: begin
          st_nxt.ctrl_a = apb_req.pwdata[2:0];
        end
        TWG_OFS_CTRL_B: begin
          st_nxt.ctrl_b = apb_req.pwdata[2:0];
        end
        TWG_OFS_IER: begin
          st_nxt.ier = apb_req.pwdata[3:0];
          // Flags clear here too, by writing one
          st_nxt.status[TWG_ST_TA] = st_r.status[TWG_ST_TA]
                                     && !apb_req.pwdata[TWG_IER_FLAG_A];
          st_nxt.status[TWG_ST_TB] = st_r.status[TWG_ST_TB]
                                     && !apb_req.pwdata[TWG_IER_FLAG_B];
        end
        TWG_OFS_STAT: begin
          st_nxt.status = st_r.status & ~apb_req.pwdata[TWG_ST_W-1:0];
        end
        TWG_OFS_MASK: begin
          st_nxt.mask = apb_req.pwdata[TWG_ST_W-1:0];
        end
        default: begin
          // Backup words are written by their own process
          st_nxt.mask = st_r.mask;
        end
      endcase
    end

    // A clear that meets a new event in one cycle must not lose
    // that event, so the set is applied after the clears.
    // Hardware set wins over a clear in the same cycle
    st_nxt.status = st_nxt.status | set_bits;

    // Level interrupt follows unmasked, class-enabled status
    st_nxt.irq = |(st_nxt.status & st_nxt.mask & class_en);

    // The event output is a one-cycle pulse, not a level; it suits
    // a wake-up path rather than software polling.
    // Event pulse per class enable
    st_nxt.evt = (any_tamper && st_r.ier[TWG_IER_TEVT])
                 || (any_wave && st_r.ier[TWG_IER_WEVT]);
  end

  // Asynchronous reset clears control and flags; the bank is a
  // separate process and keeps its words.
  // Control state register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // All words clear in one cycle, so no read sees a half-wiped bank
  // Backup bank: no reset, so system reset leaves it intact; a wipe wins
  always_ff @(posedge clock) begin
    if (wipe) begin
      for (int i = 0; i < BKP_WORDS; i++) begin
        bkp_mem[i] <= '0;
      end
    end else if (wr && bkp_hit) begin
      bkp_mem[bkp_idx] <= apb_req.pwdata[TWG_BKP_W-1:0];
    end
  end

  // Both paths share one half period; each checker compares the
  // return just before it toggles, giving the loop a whole half
  // period to settle through the pads.
  // Wave path a: out on first pad, back on second pad
  twg_wave_check #(
    .HALF_CYC(WAVE_HALF_CYC)
  ) u_wave_a (
    .clock(clock),
    .rst_b(rst_b),
    .enable(wave_check_a_select),
    .wave_in(pad_in.second_intrusion_pad),
    .wave_o(wave_a_o),
    .wave_oe(wave_a_oe),
    .fault(wave_a_fault)
  );

  // Path b borrows the oscillator pads, so the slow crystal cannot
  // run while it is selected.
  // Wave path b: out on oscillator in pad, back on oscillator out pad
  twg_wave_check #(
    .HALF_CYC(WAVE_HALF_CYC)
  ) u_wave_b (
    .clock(clock),
    .rst_b(rst_b),
    .enable(wave_check_b_select),
    .wave_in(pad_in.osc_out_pad),
    .wave_o(wave_b_o),
    .wave_oe(wave_b_oe),
    .fault(wave_b_fault)
  );

  // Pad drive comes from the checker flops, so the top still drives
  // every output straight from a flop.
  // Outputs straight from flops
  assign apb_rsp = st_r.rsp;
  assign irq = st_r.irq;
  assign tamper_event = st_r.evt;
  assign pad_out.first_intrusion_pad_o = wave_a_o;
  assign pad_out.first_intrusion_pad_oe = wave_a_oe;
  assign pad_out.osc_in_pad_o = wave_b_o;
  assign pad_out.osc_in_pad_oe = wave_b_oe;

endmodule
`default_nettype wire

// ---- dv/twg_guard_checker.sv ----
// Checker for the guard's APB answers, wave drive and event outputs.
// Assumes it is bound to twg_guard and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module twg_guard_checker import twg_pkg::*; #(
  parameter int BKP_WORDS = TWG_BKP_WORDS,
  parameter int WAVE_HALF_CYC = TWG_WAVE_HALF_CYC
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire twg_pkg::twg_apb_req_type apb_req,
  input wire twg_pkg::twg_apb_rsp_type apb_rsp,
  input wire twg_pkg::twg_pad_in_type pad_in,
  input wire twg_pkg::twg_pad_out_type pad_out,
  input wire logic irq,
  input wire logic tamper_event
);
  logic mapped; // Address hits a register or a bank word
  logic wa_q; // Last wave a level
  logic wa_arm; // A first toggle was seen
  int wa_cnt; // Cycles since the last toggle
  assign mapped = apb_req.paddr[1:0] == 2'h0 && (apb_req.paddr <= TWG_OFS_MASK ||
    (apb_req.paddr >= TWG_OFS_BKP && apb_req.paddr < TWG_OFS_BKP + 4 * BKP_WORDS));
  // Wave a spacing; arming waits for a toggle since the start phase is free
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wa_q <= 1'b0;
      wa_arm <= 1'b0;
      wa_cnt <= 0;
    end else begin
      wa_q <= pad_out.first_intrusion_pad_o;
      wa_arm <= pad_out.first_intrusion_pad_oe && (wa_arm || wa_q != pad_out.first_intrusion_pad_o);
      wa_cnt <= (wa_q != pad_out.first_intrusion_pad_o) ? 0 : wa_cnt + 1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // Setup phase of a transfer
  sequence s_setup;
    apb_req.psel && !apb_req.penable;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> apb_rsp.pready)
    else $error("pready missing in first access cycle");
  a_ready_one_cycle: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready stood more than one cycle");
  a_idle_answer_zero: assert property (!apb_rsp.pready |-> apb_rsp.prdata == 32'h0 && !apb_rsp.pslverr)
    else $error("answer lines busy while idle");
  a_err_unmapped: assert property (apb_rsp.pready && apb_req.psel && !mapped |-> apb_rsp.pslverr)
    else $error("unmapped access not refused");
  a_ok_mapped: assert property (apb_rsp.pready && apb_req.psel && mapped |-> !apb_rsp.pslverr)
    else $error("mapped access refused");
  a_event_one_pulse: assert property (tamper_event |=> !tamper_event)
    else $error("event output held too long");
  a_reset_quiet: assert property ($rose(rst_b) |-> !irq && !tamper_event)
    else $error("outputs active right after reset");
  a_wave_a_half: assert property (wa_arm && pad_out.first_intrusion_pad_oe &&
    wa_q != pad_out.first_intrusion_pad_o |-> wa_cnt == WAVE_HALF_CYC - 1)
    else $error("wave a half period wrong");
  a_wave_b_hold: assert property (pad_out.osc_in_pad_oe && $past(pad_out.osc_in_pad_oe) &&
    $changed(pad_out.osc_in_pad_o) |=> !pad_out.osc_in_pad_oe || $stable(pad_out.osc_in_pad_o))
    else $error("wave b toggled twice in a row");
endmodule
`default_nettype wire

// ---- dv/twg_pad_model.sv ----
// Far side of the pads: two tamper switches and the two wave loops.
// Assumes the bench moves switches and loop cuts right after an edge.
`timescale 1ns/10ps
`default_nettype none
module twg_pad_model import twg_pkg::*; (
  input wire logic clock,
  input wire twg_pkg::twg_pad_out_type pad_out,
  input wire logic sw_a,
  input wire logic sw_b,
  input wire logic [1:0] cut,
  output twg_pkg::twg_pad_in_type pad_in
);
  logic spin = 1'b0; // Undriven return wanders every cycle
  // Free toggle, so an idle loop never looks like a steady wave
  always @(posedge clock) begin
    spin <= !spin;
  end
  // Driven pad shows the block's level, else the switch
  assign pad_in.first_intrusion_pad = pad_out.first_intrusion_pad_oe ?
    pad_out.first_intrusion_pad_o : sw_a;
  // Loop a returns the wave, inverted when the bench cuts it
  assign pad_in.second_intrusion_pad = pad_out.first_intrusion_pad_oe ?
    pad_out.first_intrusion_pad_o ^ cut[0] : sw_b;
  // Loop b has no switch behind it
  assign pad_in.osc_out_pad = pad_out.osc_in_pad_oe ?
    pad_out.osc_in_pad_o ^ cut[1] : spin;
endmodule
`default_nettype wire

// ---- dv/twg_guard_tb.sv ----
// Self-checking bench for the tamper and wave guard over APB.
// Assumes the hand-over timing; the pad model closes both wave loops.
`timescale 1ns/10ps
`default_nettype none
module twg_guard_tb;
  import twg_pkg::*;
  localparam int HALF = 2; // Short wave half period keeps the run brief
  logic clock;
  logic rst_b;
  twg_apb_req_type req;
  twg_apb_rsp_type rsp;
  twg_pad_in_type pin;
  twg_pad_out_type pout;
  logic irq;
  logic tev;
  logic sw_a;
  logic sw_b;
  logic [1:0] cut; // Loop faults commanded by the bench
  logic [32:0] exp_q[$]; // Expected {error, data} of pending reads
  int miscompares;
  int n_checks;
  int n_ev; // Event pulses seen so far
  int ev0;
  integer seed;
  logic [31:0] val;
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  twg_guard #(.WAVE_HALF_CYC(HALF)) i_dut (.clock(clock), .rst_b(rst_b), .apb_req(req),
    .apb_rsp(rsp), .pad_in(pin), .pad_out(pout), .irq(irq), .tamper_event(tev));
  twg_pad_model i_pads (.clock(clock), .pad_out(pout), .sw_a(sw_a), .sw_b(sw_b),
    .cut(cut), .pad_in(pin));
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task summarize();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // One APB transfer; a read leaves its expected answer in the queue
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [32:0] e);
    @(posedge clock);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    if (!w) exp_q.push_back(e);
    @(posedge clock);
    req.penable <= 1'b1;
    // Only the watchdog ends a wait for pready
    do begin
      @(posedge clock);
    end while (rsp.pready !== 1'b1);
    req <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h0, e);
  endtask
  function automatic logic [7:0] bk(input int i);
    return TWG_OFS_BKP + 8'(4 * i);
  endfunction
  // Read answers are matched against the oldest note
  always @(posedge clock) begin
    if (rst_b === 1'b1 && rsp.pready === 1'b1 && req.psel === 1'b1 && req.pwrite === 1'b0) begin
      chk({rsp.pslverr, rsp.prdata}, exp_q.size() > 0 ? exp_q.pop_front() : 33'hX);
    end
  end
  // Count event pulses
  always @(posedge clock) begin
    if (tev === 1'b1) n_ev++;
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    summarize();
  end
  initial begin
    seed = 32'h431F;
    req = '0;
    rst_b = 1'b0;
    sw_a = 1'b1;
    sw_b = 1'b0;
    cut = 2'h0;
    miscompares = 0;
    n_checks = 0;
    n_ev = 0;
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    // Registers clear, holes and the word past the bank refused
    for (int i = 0; i <= 16; i += 4) rd(8'(i), 33'h0);
    rd(8'h20, {1'b1, 32'h0});
    rd(8'h41, {1'b1, 32'h0});
    rd(bk(TWG_BKP_WORDS), {1'b1, 32'h0});
    // Random fill; only the low half word is kept
    for (int i = 0; i < TWG_BKP_WORDS; i++) begin
      val = $random(seed);
      wr(bk(i), val);
      rd(bk(i), {17'h0, val[15:0]});
    end
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    rd(bk(TWG_BKP_WORDS - 1), {17'h0, val[15:0]});
    // Tamper a, active low: silent while disarmed, then trips
    wr(TWG_OFS_IER, 32'h3);
    wr(TWG_OFS_MASK, 32'hF);
    wr(TWG_OFS_CTRL_A, 32'h0);
    sw_a <= 1'b0;
    repeat (6) @(posedge clock);
    chk({32'h0, irq}, 33'h0);
    chk(33'(n_ev), 33'h0);
    sw_a <= 1'b1;
    wr(TWG_OFS_CTRL_A, 32'h1);
    sw_a <= 1'b0;
    repeat (6) @(posedge clock);
    chk({32'h0, irq}, 33'h1);
    chk(33'(n_ev), 33'h1);
    rd(TWG_OFS_STAT, 33'h1);
    for (int i = 0; i < TWG_BKP_WORDS; i += 41) rd(bk(i), 33'h0);
    rd(TWG_OFS_STAT, 33'h1);
    rd(TWG_OFS_IER, 33'h103);
    wr(TWG_OFS_IER, 32'h103);
    rd(TWG_OFS_STAT, 33'h0);
    wr(TWG_OFS_CTRL_A, 32'h0);
    sw_a <= 1'b1;
    repeat (2) @(posedge clock);
    chk({32'h0, irq}, 33'h0);
    // Tamper b, active high, irq only and masked at first
    wr(TWG_OFS_IER, 32'h1);
    wr(TWG_OFS_MASK, 32'hD);
    wr(TWG_OFS_CTRL_B, 32'h2);
    wr(TWG_OFS_CTRL_B, 32'h3);
    sw_b <= 1'b1;
    repeat (6) @(posedge clock);
    chk({32'h0, irq}, 33'h0);
    chk(33'(n_ev), 33'h1);
    rd(TWG_OFS_STAT, 33'h2);
    wr(TWG_OFS_MASK, 32'hF);
    repeat (2) @(posedge clock);
    chk({32'h0, irq}, 33'h1);
    wr(TWG_OFS_CTRL_B, 32'h0);
    sw_b <= 1'b0;
    wr(TWG_OFS_STAT, 32'hF);
    // Both wave paths: an intact loop stays quiet, a cut one trips
    wr(TWG_OFS_IER, 32'hC);
    for (int k = 0; k < 2; k++) begin
      wr(bk(7), 32'h1234);
      ev0 = n_ev;
      wr(k ? TWG_OFS_CTRL_B : TWG_OFS_CTRL_A, 32'h4);
      repeat (12) @(posedge clock);
      chk({31'h0, pout.osc_in_pad_oe, pout.first_intrusion_pad_oe}, 33'(k + 1));
      chk(33'(n_ev - ev0), 33'h0);
      cut[k] <= 1'b1;
      repeat (8) @(posedge clock);
      chk(33'(n_ev > ev0), 33'h1);
      chk({32'h0, irq}, 33'h1);
      wr(k ? TWG_OFS_CTRL_B : TWG_OFS_CTRL_A, 32'h0);
      cut[k] <= 1'b0;
      rd(TWG_OFS_STAT, {1'b0, k ? 32'hA : 32'h6});
      rd(bk(7), 33'h0);
      wr(TWG_OFS_STAT, 32'hF);
    end
    summarize();
  end
endmodule
bind twg_guard twg_guard_checker #(.BKP_WORDS(BKP_WORDS), .WAVE_HALF_CYC(WAVE_HALF_CYC)) i_chk (
  .clock(clock), .rst_b(rst_b), .apb_req(apb_req), .apb_rsp(apb_rsp), .pad_in(pad_in),
  .pad_out(pad_out), .irq(irq), .tamper_event(tamper_event));
`default_nettype wire
